// ---- design/lpst_serializer_tx.sv ----
`timescale 1ns/100ps
`include "lpst_defines.svh"

module lpst_serializer_tx #(
  parameter int LOCK_CYCLES = `LPST_LOCK_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      shift_clock_in,
  input  wire logic                      bit_clock_in,
  input  wire logic                      strobe_edge_select,
  input  wire logic                      power_down_n,
  input  wire lpst_pkg::lpst_pixel_t     pixel_in,
  output logic                           pll_enable,
  output logic [`LPST_LANES-1:0]         serial_lane_out,
  output logic [`LPST_LANES-1:0]         serial_lane_oe,
  output logic                           forwarded_clock_out,
  output logic                           forwarded_clock_oe
);
  import lpst_pkg::*;

  localparam logic [`LPST_LOCK_CNT_W-1:0] LOCK_LAST =
    `LPST_LOCK_CNT_W'(LOCK_CYCLES - 1);

  // ---------------- system clock domain: power sequencing ----------------
  logic                         pd_m_ff;
  logic                         pd_s_ff;
  lpst_state_t                  state_ff;
  lpst_state_t                  nxt_state;
  logic [`LPST_LOCK_CNT_W-1:0]  cnt_ff;
  logic [`LPST_LOCK_CNT_W-1:0]  nxt_cnt;

  // power-down pin is asynchronous, two flops before the sequencer uses it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pd_m_ff <= 1'b0;
      pd_s_ff <= 1'b0;
    end else begin
      pd_m_ff <= power_down_n;
      pd_s_ff <= pd_m_ff;
    end
  end

  // lock wait: the pll gets the full lock time before any toggling
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      LPST_ST_OFF: begin
        nxt_cnt = '0;
        if (pd_s_ff) nxt_state = LPST_ST_LOCKING;
      end
      LPST_ST_LOCKING: begin
        if (cnt_ff == LOCK_LAST) nxt_state = LPST_ST_RUN;
        else nxt_cnt = cnt_ff + `LPST_LOCK_CNT_W'(1);
      end
      LPST_ST_RUN: nxt_cnt = '0;
      default: nxt_state = LPST_ST_OFF;
    endcase
    if (!pd_s_ff) begin
      nxt_state = LPST_ST_OFF;
      nxt_cnt   = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= LPST_ST_OFF;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // pll held off while powered down so it relocks from a clean reset
  assign pll_enable = (state_ff != LPST_ST_OFF);

  // ---------------- shift clock domain: word capture ----------------
  lpst_pixel_t cap_r_ff;
  lpst_pixel_t cap_f_ff;

  // capture on both edges, the strap picks which one is used
  always_ff @(posedge shift_clock_in) begin
    cap_r_ff <= pixel_in;
  end

  always_ff @(negedge shift_clock_in) begin
    cap_f_ff <= pixel_in;
  end

  // ---------------- bit clock domain: serialiser ----------------
  // the bit clock is locked to the shift clock by the pll, so the captured
  // word is stable across slot 6; no extra crossing is needed there
  logic                     run_m_ff;
  logic                     run_b_ff;
  logic                     edge_m_ff;
  logic                     edge_b_ff;
  logic [2:0]               slot_ff;
  logic [2:0]               nxt_slot;
  logic                     fwd_ff;
  logic                     nxt_fwd;
  logic [`LPST_WORD_W-1:0]  word_sel;
  logic [`LPST_SLOTS-1:0]   fwd_pat;

  // run level and strap cross into the bit domain through two flops
  always_ff @(posedge bit_clock_in) begin
    run_m_ff  <= (state_ff == LPST_ST_RUN);
    run_b_ff  <= run_m_ff;
    edge_m_ff <= strobe_edge_select;
    edge_b_ff <= edge_m_ff;
  end

  assign fwd_pat  = `LPST_FWD_PATTERN;
  assign word_sel = edge_b_ff ? cap_r_ff : cap_f_ff;

  // slot counter; parked on the last slot so the first frame is whole
  always_comb begin
    nxt_slot = (slot_ff == `LPST_LAST_SLOT) ? 3'h0 : slot_ff + 3'h1;
    if (!run_b_ff) nxt_slot = `LPST_LAST_SLOT;
    nxt_fwd = run_b_ff & fwd_pat[3'h6 - nxt_slot];
  end

  always_ff @(posedge bit_clock_in) begin
    slot_ff <= nxt_slot;
    fwd_ff  <= nxt_fwd;
  end

  assign forwarded_clock_out = fwd_ff;

  logic [`LPST_SLOTS-1:0] lane_sr_ff [`LPST_LANES];

  // one shift register per lane, lane k carries word bits 7k+6 down to 7k
  for (genvar k = 0; k < `LPST_LANES; k++) begin : g_lane
    logic [`LPST_SLOTS-1:0] nxt_sr;

    always_comb begin
      if (!run_b_ff) nxt_sr = '0;
      else if (slot_ff == `LPST_LAST_SLOT)
        nxt_sr = word_sel[`LPST_SLOTS*k +: `LPST_SLOTS];
      else nxt_sr = {lane_sr_ff[k][`LPST_SLOTS-2:0], 1'b0};
    end

    always_ff @(posedge bit_clock_in) begin
      lane_sr_ff[k] <= nxt_sr;
    end

    assign serial_lane_out[k] = lane_sr_ff[k][`LPST_SLOTS-1];
  end

  // enables follow the pin directly: a synchroniser would miss 100 ns
  assign serial_lane_oe     = {`LPST_LANES{power_down_n & run_b_ff}};
  assign forwarded_clock_oe = power_down_n & run_b_ff;

  // ---------------- checks ----------------
  sequence s_fwd_high2;
    forwarded_clock_out [*2];
  endsequence

  sequence s_fwd_low3;
    !forwarded_clock_out [*3];
  endsequence

  AST_PD_OFF: assert property (
    @(posedge mclk) disable iff (!rstn)
    !power_down_n |-> (serial_lane_oe == '0) && !forwarded_clock_oe)
    else $error("outputs enabled during power-down");

  AST_PD_ANYTIME: assert property (
    @(posedge mclk) disable iff (!rstn)
    !pd_s_ff |=> state_ff == LPST_ST_OFF)
    else $error("power-down did not stop the sequencer");

  AST_LOCK_EARLY: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_ff == LPST_ST_LOCKING && cnt_ff != LOCK_LAST)
      |=> state_ff != LPST_ST_RUN)
    else $error("run entered before lock time");

  AST_LOCK_DONE: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_ff == LPST_ST_LOCKING && cnt_ff == LOCK_LAST && pd_s_ff)
      |=> state_ff == LPST_ST_RUN)
    else $error("run not entered at lock time");

  AST_PLL_OFF: assert property (
    @(posedge mclk) disable iff (!rstn)
    $fell(pd_s_ff) |=> !pll_enable)
    else $error("pll left enabled in power-down");

  // only the second synchroniser flop is looked at, never the first
  AST_IDLE: assert property (
    @(posedge bit_clock_in)
    !run_b_ff |=> (serial_lane_out == '0) && !forwarded_clock_out)
    else $error("outputs toggled before lock");

  AST_SLOT_WRAP: assert property (
    @(posedge bit_clock_in) disable iff (!run_b_ff)
    slot_ff == `LPST_LAST_SLOT |=> slot_ff == 3'h0)
    else $error("slot counter did not wrap after seven");

  AST_FWD_SHAPE: assert property (
    @(posedge bit_clock_in) disable iff (!run_b_ff)
    (slot_ff == 3'h0 && $past(run_b_ff))
      |-> s_fwd_high2 ##1 s_fwd_low3 ##1 s_fwd_high2)
    else $error("forwarded clock shape wrong");

  AST_LOAD_MAP: assert property (
    @(posedge bit_clock_in) disable iff (!run_b_ff)
    slot_ff == `LPST_LAST_SLOT |=>
      lane_sr_ff[2] == $past(word_sel[20:14]) &&
      lane_sr_ff[0] == $past(word_sel[6:0]))
    else $error("word not mapped to lanes");

  AST_SHIFT: assert property (
    @(posedge bit_clock_in) disable iff (!run_b_ff)
    (slot_ff != `LPST_LAST_SLOT && $past(run_b_ff)) |=>
      lane_sr_ff[1] == {$past(lane_sr_ff[1][5:0]), 1'b0})
    else $error("lane shift register did not shift");

  // the shift domain has no reset of its own, so nothing disables this
  AST_CAP_FALL: assert property (
    @(negedge shift_clock_in)
    1'b1 |=> cap_f_ff == $past(pixel_in))
    else $error("falling edge capture lost");

endmodule : lpst_serializer_tx

// ---- design/lpst_defines.svh ----
`ifndef LPST_DEFINES_SVH
`define LPST_DEFINES_SVH

// timing of the system clock and of the lock wait
`define LPST_MCLK_PERIOD_NS 100
`define LPST_LOCK_TIME_MS   10
`define LPST_LOCK_CYCLES    ((`LPST_LOCK_TIME_MS * 1000000) / `LPST_MCLK_PERIOD_NS)
`define LPST_LOCK_CNT_W     17

// serial framing
`define LPST_LANES          3
`define LPST_SLOTS          7
`define LPST_LAST_SLOT      3'h6
`define LPST_WORD_W         21
// forwarded clock shape over the seven slots, first slot in the msb
`define LPST_FWD_PATTERN    7'h63

`endif

// ---- design/lpst_pkg.sv ----
package lpst_pkg;

  // one parallel pixel word as it arrives on the pins
  typedef struct packed {
    logic       pixel_valid;
    logic       frame_sync;
    logic       line_sync;
    logic [5:0] blue;
    logic [5:0] green;
    logic [5:0] red;
  } lpst_pixel_t;

  // power sequencing states, one-hot
  typedef enum logic [2:0] {
    LPST_ST_OFF     = 3'h1,
    LPST_ST_LOCKING = 3'h2,
    LPST_ST_RUN     = 3'h4
  } lpst_state_t;

endpackage : lpst_pkg

// ---- verification/lpst_rx_model.sv ----
`timescale 1ns/100ps
// far-side deserialiser: frames on the forwarded clock shape
module lpst_rx_model (
  input  wire logic        bclk,
  input  wire logic [2:0]  lane,
  input  wire logic        fwd,
  output logic [20:0]      word,
  output int               frames
);
  logic [6:0] fh;
  logic [6:0] sh [3];
  initial frames = 0;
  // sample mid-bit, well away from the launching edge
  always @(negedge bclk) begin
    fh = {fh[5:0], fwd};
    for (int k = 0; k < 3; k++) sh[k] = {sh[k][5:0], lane[k]};
    // released lines read z, so a dead link never frames
    if (fh === 7'h63) begin
      word = {sh[2], sh[1], sh[0]};
      frames++;
    end
  end
endmodule : lpst_rx_model

// ---- verification/lpst_serializer_tx_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin comparisons++; \
  if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module lpst_serializer_tx_tb_top;
  import lpst_pkg::*;
  logic        mclk, rstn, bclk, strap, pdn;
  logic        sclk = 1'b0;
  logic        pll_en, fwd, fwd_oe;
  logic [2:0]  lane, lane_oe;
  wire  [2:0]  lane_w;
  wire         fwd_w;
  logic [20:0] rx_word;
  lpst_pixel_t pix;
  int          frames, error_cnt, comparisons;
  int          bcnt = 0;

  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // link clock, phase unrelated to mclk; runs before enable
  initial begin
    bclk = 0;
    #7;
    forever #2.3 bclk = ~bclk;
  end
  // shift clock rebuilt from the bit clock, never stopped; seven bit
  // periods give 32.2 ns, inside the allowed shift clock period
  always @(posedge bclk) begin
    bcnt <= (bcnt == 6) ? 0 : bcnt + 1;
    sclk <= (bcnt == 6 || bcnt < 3);
  end
  // released pins float
  for (genvar k = 0; k < 3; k++) begin : g_pin
    assign lane_w[k] = lane_oe[k] ? lane[k] : 1'bz;
  end
  assign fwd_w = fwd_oe ? fwd : 1'bz;

  lpst_serializer_tx #(.LOCK_CYCLES(20)) uut (
    .mclk(mclk), .rstn(rstn), .shift_clock_in(sclk),
    .bit_clock_in(bclk), .strobe_edge_select(strap),
    .power_down_n(pdn), .pixel_in(pix), .pll_enable(pll_en),
    .serial_lane_out(lane), .serial_lane_oe(lane_oe),
    .forwarded_clock_out(fwd), .forwarded_clock_oe(fwd_oe)
  );
  lpst_rx_model u_rx (
    .bclk(bclk), .lane(lane_w), .fwd(fwd_w),
    .word(rx_word), .frames(frames)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic wait_frames(input int n);
    int t0, lim;
    t0 = frames;
    lim = 0;
    while (frames < t0 + n && lim < 2000) begin
      @(negedge mclk);
      lim++;
    end
    if (lim == 2000) begin
      error_cnt++;
      $display("[FAIL] %0t no frames", $time);
      summarize();
    end
  endtask : wait_frames

  task automatic t_power_up;
    int n;
    n = 0;
    pdn = 1;
    while (lane_oe[0] !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
      if (n < 20) `CHK(lane_oe, 3'h0, "early output")
    end
    `CHK(n >= 20 && n < 200, 1'b1, "lock wait")
    if (n >= 200) summarize();
    `CHK(pll_en, 1'b1, "pll on")
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_word(input logic s, input logic [20:0] w);
    @(negedge mclk);
    strap = s;
    pix = w;
    wait_frames(3);
    `CHK(rx_word, w, "word")
    `CHK({fwd_oe, lane_oe}, 4'hf, "pins on")
    $display("test word done");
  endtask : t_word

  // a stands while the shift clock is high, b while it is low, so only
  // the chosen strobe edge can bring the expected word to the far side
  task automatic t_edge(input logic s, input logic [20:0] a,
                        input logic [20:0] b);
    int f0;
    @(negedge mclk);
    strap = s;
    f0 = frames;
    repeat (98) begin
      @(negedge bclk);
      if (bcnt == 1) pix = a;
      if (bcnt == 5) pix = b;
    end
    `CHK(frames > f0 + 8, 1'b1, "edge frames")
    `CHK(rx_word, s ? b : a, "edge word")
    $display("test edge done");
  endtask : t_edge

  // drop power-down in mid-frame
  task automatic t_power_down;
    @(negedge mclk);
    pdn = 0;
    #1;
    `CHK({fwd_oe, lane_oe}, 4'h0, "pins off")
    repeat (3) @(negedge mclk);
    `CHK(pll_en, 1'b0, "pll off")
    $display("test power_down done");
  endtask : t_power_down

  initial begin
    error_cnt = 0;
    comparisons = 0;
    rstn = 0;
    strap = 0;
    pdn = 0;
    pix = '0;
    repeat (8) @(negedge mclk);
    rstn = 1;
    t_power_up();
    t_word(1'b0, 21'h15_a5c3);
    t_word(1'b1, 21'h0a_5a3c);
    t_edge(1'b0, 21'h0f_1234, 21'h10_edcb);
    t_edge(1'b1, 21'h0f_1234, 21'h10_edcb);
    t_power_down();
    t_power_up();
    t_word(1'b0, 21'h1f_0f01);
    summarize();
  end
endmodule : lpst_serializer_tx_tb_top
